// >>> inc/ulse_pkg.sv
// constants, register map and types for the low-speed USB function registers
package ulse_pkg;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned PID_W = 4;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned EPNUM_W = 4;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned TXEP_W = 2;

  // register offsets on the special function register port
  localparam logic [7:0] ADDR_PRESCALER = 8'hE1;
  localparam logic [7:0] ADDR_EP1_TX_DATA = 8'hE6;
  localparam logic [7:0] ADDR_EP0_TX_DATA = 8'hE7;
  localparam logic [7:0] ADDR_INT_FLAGS = 8'hE8;
  localparam logic [7:0] ADDR_INT_ENABLES = 8'hE9;
  localparam logic [7:0] ADDR_EP0_TX_CTRL = 8'hEA;
  localparam logic [7:0] ADDR_EP1_TX_CTRL = 8'hEB;
  localparam logic [7:0] ADDR_GEN_CTRL = 8'hEC;
  localparam logic [7:0] ADDR_EP0_RX_STATUS = 8'hED;
  localparam logic [7:0] ADDR_FUNC_ADDR = 8'hEE;
  localparam logic [7:0] ADDR_EP0_RX_DATA = 8'hEF;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // general control fields
  localparam int unsigned GC_AUTO_STATUS_OUT = 4;
  localparam int unsigned GC_SECOND_EP_ENABLE = 3;
  localparam int unsigned GC_FIRST_EP_ENABLE = 2;
  localparam int unsigned GC_SECOND_EP_HALT = 1;
  localparam int unsigned GC_FIRST_EP_HALT = 0;
  localparam logic [7:0] GC_WRITABLE = 8'h1F;
  localparam logic [2:0] GC_RESERVED_ZERO = 3'h0;

  // endpoint 0 receive status fields
  localparam int unsigned ST_EXPECTED_TOGGLE = 7;
  localparam int unsigned ST_SETUP_SEEN = 6;
  localparam int unsigned ST_IN_SEEN = 5;
  localparam int unsigned ST_OUT_SEEN = 4;

  // transmit control and function address fields
  localparam int unsigned TC_TOGGLE = 7;
  localparam int unsigned TC0_HALT = 6;
  localparam int unsigned TC1_EP_SELECT = 6;
  localparam int unsigned TC_TX_ENABLE = 5;
  localparam int unsigned TC0_RX_ENABLE = 4;
  localparam int unsigned FA_FUNCTION_ENABLE = 7;

  // interrupt flag positions
  localparam int unsigned IF_TX0_DONE = 4;
  localparam int unsigned IF_RX0_DONE = 3;
  localparam int unsigned IF_END_OF_PACKET = 1;

  localparam logic [3:0] PID_SETUP = 4'hD;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_DATA0 = 4'h3;
  localparam logic [3:0] PID_DATA1 = 4'hB;
  localparam logic [3:0] PID_ACK = 4'h2;
  localparam logic [3:0] PID_NAK = 4'hA;
  localparam logic [3:0] PID_STALL = 4'hE;

  localparam logic [3:0] EP_ZERO = 4'h0;
  localparam logic [3:0] EP_ONE = 4'h1;
  localparam logic [3:0] EP_TWO = 4'h2;
  localparam logic [3:0] CNT_MAX = 4'hF;

  // usb logic rate is oscillator / 2 / (prescaler + 1)
  localparam int unsigned OSC_PRE_DIVIDE = 2;
  localparam int unsigned DIV_CNT_W = 9;

  typedef enum logic [1:0] {ULSE_TOK_NONE, ULSE_TOK_SETUP, ULSE_TOK_IN, ULSE_TOK_OUT} ulse_tok_t;
  typedef enum logic {ULSE_LINK_IDLE, ULSE_LINK_RX} ulse_link_t;
endpackage : ulse_pkg

// >>> core/ulse_clk_div.sv
// enable-pulse divider giving the usb logic rate from the prescaler
`timescale 1ns/10ps
`default_nettype none
module ulse_clk_div #(
  parameter int unsigned CNT_W = ulse_pkg::DIV_CNT_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [ulse_pkg::BYTE_W-1:0] presc_i,
  output logic en_o
);
  import ulse_pkg::*;

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] term;

  if (CNT_W < BYTE_W + 1) begin : g_chk
    $error("divider counter too narrow for the prescaler");
  end

  // terminal count is 2*(presc+1)-1
  assign term = CNT_W'((OSC_PRE_DIVIDE * (int'(presc_i) + 1)) - 1);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      cnt_ff <= '0;
      en_o <= 1'b0;
    end else if (cnt_ff >= term) begin
      // >= so a prescaler lowered mid-count still wraps
      cnt_ff <= '0;
      en_o <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + CNT_W'(1);
      en_o <= 1'b0;
    end
  end

  property p_div_by_two;
    en_o && presc_i == 8'h00 ##1 presc_i == 8'h00 |-> !en_o ##1 en_o;
  endproperty
  a_div_by_two: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) p_div_by_two)
    else $error("usb enable not every second cycle at prescaler zero");
endmodule : ulse_clk_div
`default_nettype wire

// >>> core/ulse_tok_filter.sv
// token address filter and pid decode, one cycle of latency
`timescale 1ns/10ps
`default_nettype none
module ulse_tok_filter (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic tok_valid_i,
  input wire logic [ulse_pkg::PID_W-1:0] tok_pid_i,
  input wire logic [ulse_pkg::FADDR_W-1:0] tok_addr_i,
  input wire logic [ulse_pkg::EPNUM_W-1:0] tok_ep_i,
  input wire logic [ulse_pkg::FADDR_W-1:0] function_address_field_i,
  input wire logic function_enable_i,
  output logic hit_o,
  output var ulse_pkg::ulse_tok_t kind_o,
  output logic [ulse_pkg::EPNUM_W-1:0] ep_o
);
  import ulse_pkg::*;

  function automatic ulse_tok_t decode(input logic [3:0] pid);
    case (pid)
      PID_SETUP: decode = ULSE_TOK_SETUP;
      PID_IN: decode = ULSE_TOK_IN;
      PID_OUT: decode = ULSE_TOK_OUT;
      default: decode = ULSE_TOK_NONE;
    endcase
  endfunction : decode

  logic take;
  assign take = tok_valid_i && function_enable_i && tok_addr_i == function_address_field_i
    && decode(tok_pid_i) != ULSE_TOK_NONE;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      hit_o <= 1'b0;
      kind_o <= ULSE_TOK_NONE;
      ep_o <= '0;
    end else begin
      hit_o <= take;
      kind_o <= take ? decode(tok_pid_i) : ULSE_TOK_NONE;
      ep_o <= tok_ep_i;
    end
  end

  property p_addr_match;
    hit_o |-> $past(function_enable_i) && $past(tok_addr_i) == $past(function_address_field_i);
  endproperty
  a_addr_match: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) p_addr_match)
    else $error("token taken for a foreign address or while disabled");
endmodule : ulse_tok_filter
`default_nettype wire

// >>> core/ulse_core.sv
// register file and endpoint handshake logic of the low-speed usb function
`timescale 1ns/10ps
`default_nettype none
module ulse_core (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [ulse_pkg::BYTE_W-1:0] sfr_wdata_i,
  output logic [ulse_pkg::BYTE_W-1:0] sfr_rdata_o,
  input wire logic tok_valid_i,
  input wire logic [ulse_pkg::PID_W-1:0] tok_pid_i,
  input wire logic [ulse_pkg::FADDR_W-1:0] tok_addr_i,
  input wire logic [ulse_pkg::EPNUM_W-1:0] tok_ep_i,
  input wire logic rx_byte_valid_i,
  input wire logic [ulse_pkg::BYTE_W-1:0] rx_byte_i,
  input wire logic rx_end_i,
  input wire logic [ulse_pkg::PID_W-1:0] rx_pid_i,
  input wire logic tx_ack_i,
  output logic usb_clk_en_o,
  output logic hs_valid_o,
  output logic [ulse_pkg::PID_W-1:0] hs_pid_o,
  output logic tx_start_o,
  output logic [ulse_pkg::PID_W-1:0] tx_pid_o,
  output logic [ulse_pkg::TXEP_W-1:0] tx_ep_o,
  output logic [ulse_pkg::CNT_W-1:0] tx_len_o,
  output logic [ulse_pkg::BYTE_W-1:0] tx_data_o,
  output logic irq_o
);
  import ulse_pkg::*;

  logic [7:0] presc_ff;
  logic [7:0] ep1_txd_ff;
  logic [7:0] ep0_txd_ff;
  logic [7:0] iflag_ff;
  logic [7:0] ien_ff;
  logic [7:0] tc0_ff;
  logic [7:0] tc1_ff;
  logic [7:0] gc_ff;
  logic [7:0] stat_ff;
  logic [7:0] fadr_ff;
  logic [7:0] rxd_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] flag_set;
  ulse_link_t link_ff;
  ulse_tok_t rx_kind_ff;
  logic [3:0] rx_cnt_ff;
  logic last_tx_ep0_ff;
  logic usb_en;

  logic tok_hit;
  ulse_tok_t tok_kind;
  logic [3:0] tok_ep;

  function automatic logic [3:0] data_pid(input logic toggle);
    data_pid = toggle ? PID_DATA1 : PID_DATA0;
  endfunction : data_pid

  ulse_clk_div #(
    .CNT_W(DIV_CNT_W)
  ) u_div (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .presc_i(presc_ff),
    .en_o(usb_en)
  );

  ulse_tok_filter u_tok (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .tok_valid_i(tok_valid_i),
    .tok_pid_i(tok_pid_i),
    .tok_addr_i(tok_addr_i),
    .tok_ep_i(tok_ep_i),
    .function_address_field_i(fadr_ff[FADDR_W-1:0]),
    .function_enable_i(fadr_ff[FA_FUNCTION_ENABLE]),
    .hit_o(tok_hit),
    .kind_o(tok_kind),
    .ep_o(tok_ep)
  );

  // divider output is already a flop; this adds one more stage to keep outputs registered
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      usb_clk_en_o <= 1'b0;
    end else begin
      usb_clk_en_o <= usb_en;
    end
  end

  logic wr_stat;
  logic wr_flags;
  assign wr_stat = sfr_wr_i && sfr_addr_i == ADDR_EP0_RX_STATUS;
  assign wr_flags = sfr_wr_i && sfr_addr_i == ADDR_INT_FLAGS;

  // plain read/write registers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      presc_ff <= REG_RESET;
      ep1_txd_ff <= REG_RESET;
      ep0_txd_ff <= REG_RESET;
      ien_ff <= REG_RESET;
      tc0_ff <= REG_RESET;
      tc1_ff <= REG_RESET;
      gc_ff <= REG_RESET;
      fadr_ff <= REG_RESET;
    end else if (sfr_wr_i) begin
      case (sfr_addr_i)
        ADDR_PRESCALER: presc_ff <= sfr_wdata_i;
        ADDR_EP1_TX_DATA: ep1_txd_ff <= sfr_wdata_i;
        ADDR_EP0_TX_DATA: ep0_txd_ff <= sfr_wdata_i;
        ADDR_INT_ENABLES: ien_ff <= sfr_wdata_i;
        ADDR_EP0_TX_CTRL: tc0_ff <= sfr_wdata_i;
        ADDR_EP1_TX_CTRL: tc1_ff <= sfr_wdata_i;
        ADDR_GEN_CTRL: gc_ff <= sfr_wdata_i & GC_WRITABLE;
        ADDR_FUNC_ADDR: fadr_ff <= sfr_wdata_i;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (sfr_addr_i)
      ADDR_PRESCALER: nxt_rdata = presc_ff;
      ADDR_EP1_TX_DATA: nxt_rdata = ep1_txd_ff;
      ADDR_EP0_TX_DATA: nxt_rdata = ep0_txd_ff;
      ADDR_INT_FLAGS: nxt_rdata = iflag_ff;
      ADDR_INT_ENABLES: nxt_rdata = ien_ff;
      ADDR_EP0_TX_CTRL: nxt_rdata = tc0_ff;
      ADDR_EP1_TX_CTRL: nxt_rdata = tc1_ff;
      ADDR_GEN_CTRL: nxt_rdata = gc_ff;
      ADDR_EP0_RX_STATUS: nxt_rdata = stat_ff;
      ADDR_FUNC_ADDR: nxt_rdata = fadr_ff;
      ADDR_EP0_RX_DATA: nxt_rdata = rxd_ff;
      default: nxt_rdata = UNMAPPED_READ;
    endcase
  end

  // read data holds until the next read strobe
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      sfr_rdata_o <= REG_RESET;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= nxt_rdata;
    end
  end

  // receive data stage on endpoint 0
  logic rx_done;
  logic rx_auto;
  logic rx_accept;
  logic rx_match;
  logic rx_good;
  assign rx_done = link_ff == ULSE_LINK_RX && rx_end_i;
  assign rx_auto = rx_done && gc_ff[GC_AUTO_STATUS_OUT] && rx_kind_ff == ULSE_TOK_OUT
    && rx_cnt_ff == '0;
  assign rx_accept = rx_kind_ff == ULSE_TOK_SETUP || tc0_ff[TC0_RX_ENABLE];
  assign rx_match = (rx_pid_i == PID_DATA1) == stat_ff[ST_EXPECTED_TOGGLE];
  assign rx_good = rx_done && !rx_auto && rx_accept && rx_match;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      link_ff <= ULSE_LINK_IDLE;
      rx_kind_ff <= ULSE_TOK_NONE;
      rx_cnt_ff <= '0;
    end else begin
      case (link_ff)
        ULSE_LINK_IDLE: begin
          if (tok_hit && tok_ep == EP_ZERO && tok_kind != ULSE_TOK_IN) begin
            link_ff <= ULSE_LINK_RX;
            rx_kind_ff <= tok_kind;
            rx_cnt_ff <= '0;
          end
        end
        ULSE_LINK_RX: begin
          // a fresh token abandons a data stage the host never finished
          if (rx_end_i || tok_hit) begin
            link_ff <= ULSE_LINK_IDLE;
          end else if (rx_byte_valid_i && rx_cnt_ff != CNT_MAX) begin
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
          end
        end
        default: link_ff <= ULSE_LINK_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rxd_ff <= REG_RESET;
    end else if (link_ff == ULSE_LINK_RX && rx_byte_valid_i) begin
      rxd_ff <= rx_byte_i;
    end
  end

  // endpoint 0 status register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      stat_ff <= REG_RESET;
    end else begin
      if (tok_hit && tok_ep == EP_ZERO) begin
        stat_ff[ST_SETUP_SEEN] <= tok_kind == ULSE_TOK_SETUP;
        stat_ff[ST_IN_SEEN] <= tok_kind == ULSE_TOK_IN;
        stat_ff[ST_OUT_SEEN] <= tok_kind == ULSE_TOK_OUT;
      end
      // hardware flip wins over a software write in the same cycle
      if (rx_good) begin
        stat_ff[ST_EXPECTED_TOGGLE] <= !stat_ff[ST_EXPECTED_TOGGLE];
      end else if (wr_stat) begin
        stat_ff[ST_EXPECTED_TOGGLE] <= sfr_wdata_i[ST_EXPECTED_TOGGLE];
      end
      if (rx_good) begin
        stat_ff[CNT_W-1:0] <= rx_cnt_ff;
      end
    end
  end

  // endpoint 1/2 selection for IN tokens
  logic ep12_on;
  logic ep12_halt;
  logic ep12_ready;
  assign ep12_on = (tok_ep == EP_ONE && gc_ff[GC_FIRST_EP_ENABLE])
    || (tok_ep == EP_TWO && gc_ff[GC_SECOND_EP_ENABLE]);
  assign ep12_halt = (tok_ep == EP_ONE && gc_ff[GC_FIRST_EP_HALT])
    || (tok_ep == EP_TWO && gc_ff[GC_SECOND_EP_HALT]);
  assign ep12_ready = tc1_ff[TC_TX_ENABLE] && tc1_ff[TC1_EP_SELECT] == (tok_ep == EP_TWO);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      hs_valid_o <= 1'b0;
      hs_pid_o <= '0;
      tx_start_o <= 1'b0;
      tx_pid_o <= '0;
      tx_ep_o <= '0;
      tx_len_o <= '0;
      tx_data_o <= '0;
      last_tx_ep0_ff <= 1'b0;
    end else begin
      hs_valid_o <= 1'b0;
      tx_start_o <= 1'b0;
      if (rx_done) begin
        hs_valid_o <= 1'b1;
        hs_pid_o <= (rx_auto || rx_accept) ? PID_ACK : PID_NAK;
      end else if (tok_hit && tok_kind == ULSE_TOK_IN && tok_ep == EP_ZERO) begin
        if (tc0_ff[TC0_HALT]) begin
          hs_valid_o <= 1'b1;
          hs_pid_o <= PID_STALL;
        end else if (tc0_ff[TC_TX_ENABLE]) begin
          tx_start_o <= 1'b1;
          tx_pid_o <= data_pid(tc0_ff[TC_TOGGLE]);
          tx_ep_o <= tok_ep[TXEP_W-1:0];
          tx_len_o <= tc0_ff[CNT_W-1:0];
          tx_data_o <= ep0_txd_ff;
          last_tx_ep0_ff <= 1'b1;
        end else begin
          hs_valid_o <= 1'b1;
          hs_pid_o <= PID_NAK;
        end
      end else if (tok_hit && tok_kind == ULSE_TOK_IN && ep12_on) begin
        if (ep12_halt) begin
          hs_valid_o <= 1'b1;
          hs_pid_o <= PID_STALL;
        end else if (ep12_ready) begin
          tx_start_o <= 1'b1;
          tx_pid_o <= data_pid(tc1_ff[TC_TOGGLE]);
          tx_ep_o <= tok_ep[TXEP_W-1:0];
          tx_len_o <= tc1_ff[CNT_W-1:0];
          tx_data_o <= ep1_txd_ff;
          last_tx_ep0_ff <= 1'b0;
        end else begin
          hs_valid_o <= 1'b1;
          hs_pid_o <= PID_NAK;
        end
      end
    end
  end

  // interrupt flags: write 0 clears, a set in the same cycle wins
  always_comb begin
    flag_set = '0;
    flag_set[IF_RX0_DONE] = rx_good;
    flag_set[IF_TX0_DONE] = tx_ack_i && last_tx_ep0_ff;
    flag_set[IF_END_OF_PACKET] = rx_done;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      iflag_ff <= REG_RESET;
    end else if (wr_flags) begin
      iflag_ff <= (iflag_ff & sfr_wdata_i) | flag_set;
    end else begin
      iflag_ff <= iflag_ff | flag_set;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(iflag_ff & ien_ff);
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  property p_auto_status;
    rx_done && gc_ff[GC_AUTO_STATUS_OUT] && rx_kind_ff == ULSE_TOK_OUT && rx_cnt_ff == 4'h0
      |=> hs_valid_o && hs_pid_o == PID_ACK && $stable(stat_ff[3:0]);
  endproperty
  a_auto_status: assert property (p_auto_status)
    else $error("zero-length status OUT not acknowledged automatically");

  property p_ep2_off;
    tok_hit && tok_ep == EP_TWO && !gc_ff[GC_SECOND_EP_ENABLE] |=> !hs_valid_o && !tx_start_o;
  endproperty
  a_ep2_off: assert property (p_ep2_off)
    else $error("disabled endpoint 2 answered");

  property p_ep1_off;
    tok_hit && tok_ep == EP_ONE && !gc_ff[GC_FIRST_EP_ENABLE] |=> !hs_valid_o && !tx_start_o;
  endproperty
  a_ep1_off: assert property (p_ep1_off)
    else $error("disabled endpoint 1 answered");

  property p_ep2_stall;
    tok_hit && tok_kind == ULSE_TOK_IN && tok_ep == EP_TWO && gc_ff[3:1] == 3'h5
      |=> hs_valid_o && hs_pid_o == PID_STALL && !tx_start_o;
  endproperty
  a_ep2_stall: assert property (p_ep2_stall)
    else $error("halted endpoint 2 did not stall");

  property p_ep1_stall;
    tok_hit && tok_kind == ULSE_TOK_IN && tok_ep == EP_ONE && gc_ff[2] && gc_ff[0]
      |=> hs_valid_o && hs_pid_o == PID_STALL && !tx_start_o;
  endproperty
  a_ep1_stall: assert property (p_ep1_stall)
    else $error("halted endpoint 1 did not stall");

  property p_toggle_flip;
    rx_good |=> stat_ff[ST_EXPECTED_TOGGLE] != $past(stat_ff[ST_EXPECTED_TOGGLE]);
  endproperty
  a_toggle_flip: assert property (p_toggle_flip)
    else $error("expected toggle not advanced after good data");

  property p_setup_flag;
    tok_hit && tok_ep == EP_ZERO && tok_kind == ULSE_TOK_SETUP |=> stat_ff[6:4] == 3'h4;
  endproperty
  a_setup_flag: assert property (p_setup_flag)
    else $error("setup flag not raised");

  property p_in_flag;
    tok_hit && tok_ep == EP_ZERO && tok_kind == ULSE_TOK_IN |=> stat_ff[6:4] == 3'h2;
  endproperty
  a_in_flag: assert property (p_in_flag)
    else $error("in flag not raised");

  property p_out_flag;
    tok_hit && tok_ep == EP_ZERO && tok_kind == ULSE_TOK_OUT |=> stat_ff[6:4] == 3'h1;
  endproperty
  a_out_flag: assert property (p_out_flag)
    else $error("out flag not raised");

  property p_count;
    rx_good |=> stat_ff[3:0] == $past(rx_cnt_ff);
  endproperty
  a_count: assert property (p_count)
    else $error("received byte count not reported");

  property p_irq;
    iflag_ff[IF_RX0_DONE] && ien_ff[IF_RX0_DONE] ##1 iflag_ff[IF_RX0_DONE] |-> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled flag did not raise interrupt");

  property p_reserved;
    sfr_wr_i && sfr_addr_i == ADDR_GEN_CTRL |=> gc_ff[7:5] == GC_RESERVED_ZERO;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved control bits took a write");
endmodule : ulse_core
`default_nettype wire

// >>> bench/ulse_host_model.sv
// host-side model: issues tokens and data packets at the falling edge
`timescale 1ns/10ps
`default_nettype none
module ulse_host_model (
  input wire logic ref_clk_i,
  output logic tok_valid_o,
  output logic [3:0] tok_pid_o,
  output logic [6:0] tok_addr_o,
  output logic [3:0] tok_ep_o,
  output logic rx_byte_valid_o,
  output logic [7:0] rx_byte_o,
  output logic rx_end_o,
  output logic [3:0] rx_pid_o,
  output logic tx_ack_o
);
  initial begin
    {tok_valid_o, rx_byte_valid_o, rx_end_o, tx_ack_o} = '0;
    {tok_pid_o, tok_addr_o, tok_ep_o, rx_byte_o, rx_pid_o} = '0;
  end
  // fields go to their inverse outside a strobe so stale values never match
  task automatic token(input logic [3:0] pid, input logic [6:0] adr, input logic [3:0] ep);
    @(negedge ref_clk_i);
    tok_valid_o = 1'b1;
    tok_pid_o = pid;
    tok_addr_o = adr;
    tok_ep_o = ep;
    @(negedge ref_clk_i);
    tok_valid_o = 1'b0;
    tok_pid_o = ~pid;
    tok_addr_o = ~adr;
    tok_ep_o = ~ep;
    repeat (4) @(negedge ref_clk_i);
  endtask : token
  task automatic packet(input logic [3:0] pid, input int n, input logic [7:0] b0);
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk_i);
      rx_byte_valid_o = 1'b1;
      rx_byte_o = b0 + 8'(i);
      @(negedge ref_clk_i);
      rx_byte_valid_o = 1'b0;
      rx_byte_o = ~rx_byte_o;
    end
    @(negedge ref_clk_i);
    rx_end_o = 1'b1;
    rx_pid_o = pid;
    @(negedge ref_clk_i);
    rx_end_o = 1'b0;
    rx_pid_o = ~pid;
    repeat (4) @(negedge ref_clk_i);
  endtask : packet
  task automatic ack();
    @(negedge ref_clk_i);
    tx_ack_o = 1'b1;
    @(negedge ref_clk_i);
    tx_ack_o = 1'b0;
    repeat (3) @(negedge ref_clk_i);
  endtask : ack
endmodule : ulse_host_model
`default_nettype wire

// >>> bench/tb_ulse_core.sv
// self-checking bench for the usb function register block
`timescale 1ns/10ps
`default_nettype none
module tb_ulse_core;
  import ulse_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o, rx_byte_i, tx_data_o;
  logic tok_valid_i, rx_byte_valid_i, rx_end_i, tx_ack_i, rd_d;
  logic [3:0] tok_pid_i, tok_ep_i, rx_pid_i, hs_pid_o, tx_pid_o, tx_len_o;
  logic [6:0] tok_addr_i;
  logic usb_clk_en_o, hs_valid_o, tx_start_o, irq_o;
  logic [1:0] tx_ep_o;
  int err_total = 0;
  int samples_checked = 0;
  int seed = 32'h0FF4;
  logic [7:0] rd_q[$];
  logic [3:0] hs_q[$];
  logic [17:0] tx_q[$];
  always #2 ref_clk_i = ~ref_clk_i;
  ulse_core ulse_core_inst (.ref_clk_i, .rst_b_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
    .sfr_wdata_i, .sfr_rdata_o, .tok_valid_i, .tok_pid_i, .tok_addr_i, .tok_ep_i,
    .rx_byte_valid_i, .rx_byte_i, .rx_end_i, .rx_pid_i, .tx_ack_i, .usb_clk_en_o,
    .hs_valid_o, .hs_pid_o, .tx_start_o, .tx_pid_o, .tx_ep_o, .tx_len_o, .tx_data_o, .irq_o);
  ulse_host_model host_inst (.ref_clk_i(ref_clk_i), .tok_valid_o(tok_valid_i),
    .tok_pid_o(tok_pid_i), .tok_addr_o(tok_addr_i), .tok_ep_o(tok_ep_i),
    .rx_byte_valid_o(rx_byte_valid_i), .rx_byte_o(rx_byte_i), .rx_end_o(rx_end_i),
    .rx_pid_o(rx_pid_i), .tx_ack_o(tx_ack_i));
  task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  // an empty queue yields x, so an unasked-for result always mismatches
  always @(posedge ref_clk_i) begin
    rd_d = sfr_rd_i;
    #1;
    if (rd_d) chk("sfr_rdata_o", rd_q.size() ? rd_q.pop_front() : 'x, sfr_rdata_o);
    if (hs_valid_o === 1'b1) chk("hs_pid_o", hs_q.size() ? hs_q.pop_front() : 'x, hs_pid_o);
    if (tx_start_o === 1'b1)
      chk("tx fields", tx_q.size() ? tx_q.pop_front() : 'x,
          {tx_pid_o, tx_ep_o, tx_len_o, tx_data_o});
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge ref_clk_i);
    sfr_wr_i = 1'b0;
    sfr_wdata_i = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    rd_q.push_back(e);
    @(negedge ref_clk_i);
    sfr_rd_i = 1'b0;
  endtask : rd
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    #200000;
    err_total++;
    summarize();
  end
  initial begin : main
    logic [7:0] v;
    logic [7:0] rw[7];
    int n;
    rw = '{8'hE1, 8'hE6, 8'hE7, 8'hE9, 8'hEA, 8'hEB, 8'hEE};
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    for (int a = 8'hE0; a <= 8'hEF; a++) rd(8'(a), REG_RESET);
    foreach (rw[i]) begin
      v = 8'($random(seed));
      wr(rw[i], v);
      rd(rw[i], v);
    end
    v = 8'($random(seed));
    wr(ADDR_GEN_CTRL, v);
    rd(ADDR_GEN_CTRL, v & 8'h1F);
    wr(ADDR_GEN_CTRL, 8'hFF);
    rd(ADDR_GEN_CTRL, 8'h1F);
    wr(ADDR_EP0_RX_STATUS, 8'hFF);
    rd(ADDR_EP0_RX_STATUS, 8'h80);
    wr(ADDR_EP0_RX_DATA, 8'hFF);
    rd(ADDR_EP0_RX_DATA, 8'h00);
    $display("test registers done");
    for (int p = 0; p < 3; p++) begin
      wr(ADDR_PRESCALER, 8'(p));
      repeat (8) @(posedge ref_clk_i);
      n = 0;
      repeat (48) begin
        @(posedge ref_clk_i);
        #1;
        n += (usb_clk_en_o === 1'b1);
      end
      chk("usb_clk_en_o count", 18'(48 / (OSC_PRE_DIVIDE * (p + 1))), 18'(n));
    end
    $display("test divider done");
    wr(ADDR_GEN_CTRL, 8'h00);
    wr(ADDR_EP0_RX_STATUS, 8'h00);
    wr(ADDR_EP0_TX_CTRL, 8'h00);
    wr(ADDR_INT_ENABLES, 8'h08);
    wr(ADDR_FUNC_ADDR, 8'h85);
    hs_q.push_back(PID_NAK);
    host_inst.token(PID_IN, 7'h05, EP_ZERO);
    rd(ADDR_EP0_RX_STATUS, 8'h20);
    host_inst.token(PID_OUT, 7'h06, EP_ZERO);
    wr(ADDR_FUNC_ADDR, 8'h05);
    host_inst.token(PID_OUT, 7'h05, EP_ZERO);
    rd(ADDR_EP0_RX_STATUS, 8'h20);
    wr(ADDR_FUNC_ADDR, 8'h85);
    $display("test address filter done");
    host_inst.token(PID_SETUP, 7'h05, EP_ZERO);
    rd(ADDR_EP0_RX_STATUS, 8'h40);
    hs_q.push_back(PID_ACK);
    host_inst.packet(PID_DATA0, 3, 8'hA0);
    rd(ADDR_EP0_RX_STATUS, 8'hC3);
    rd(ADDR_EP0_RX_DATA, 8'hA2);
    rd(ADDR_INT_FLAGS, 8'h0A);
    chk("irq_o", 1, irq_o);
    wr(ADDR_INT_ENABLES, 8'h00);
    @(negedge ref_clk_i);
    chk("irq_o masked", 0, irq_o);
    wr(ADDR_INT_FLAGS, 8'h00);
    rd(ADDR_INT_FLAGS, 8'h00);
    $display("test setup done");
    wr(ADDR_EP0_TX_CTRL, 8'h10);
    host_inst.token(PID_OUT, 7'h05, EP_ZERO);
    hs_q.push_back(PID_ACK);
    host_inst.packet(PID_DATA0, 2, 8'h55);
    rd(ADDR_EP0_RX_STATUS, 8'h93);
    rd(ADDR_EP0_RX_DATA, 8'h56);
    host_inst.token(PID_OUT, 7'h05, EP_ZERO);
    hs_q.push_back(PID_ACK);
    host_inst.packet(PID_DATA1, 1, 8'h77);
    rd(ADDR_EP0_RX_STATUS, 8'h11);
    wr(ADDR_INT_FLAGS, 8'h00);
    $display("test toggle done");
    wr(ADDR_EP0_TX_CTRL, 8'h00);
    wr(ADDR_GEN_CTRL, 8'h10);
    host_inst.token(PID_OUT, 7'h05, EP_ZERO);
    hs_q.push_back(PID_ACK);
    host_inst.packet(PID_DATA1, 0, 8'h00);
    rd(ADDR_EP0_RX_STATUS, 8'h11);
    rd(ADDR_INT_FLAGS, 8'h02);
    wr(ADDR_INT_FLAGS, 8'h00);
    $display("test status out done");
    for (int i = 1; i <= 2; i++) begin
      wr(ADDR_GEN_CTRL, 8'h00);
      host_inst.token(PID_IN, 7'h05, 4'(i));
      wr(ADDR_GEN_CTRL, 8'h05 << (i - 1));
      hs_q.push_back(PID_STALL);
      host_inst.token(PID_IN, 7'h05, 4'(i));
    end
    $display("test halt done");
    wr(ADDR_EP0_TX_DATA, 8'h5A);
    wr(ADDR_EP0_TX_CTRL, 8'hA3);
    tx_q.push_back({PID_DATA1, 2'b00, 4'h3, 8'h5A});
    host_inst.token(PID_IN, 7'h05, EP_ZERO);
    host_inst.ack();
    rd(ADDR_INT_FLAGS, 8'h10);
    rd(ADDR_EP0_RX_STATUS, 8'h21);
    wr(ADDR_EP0_TX_CTRL, 8'h40);
    hs_q.push_back(PID_STALL);
    host_inst.token(PID_IN, 7'h05, EP_ZERO);
    wr(ADDR_INT_FLAGS, 8'h00);
    wr(ADDR_GEN_CTRL, 8'h0C);
    wr(ADDR_EP1_TX_DATA, 8'h3C);
    wr(ADDR_EP1_TX_CTRL, 8'h62);
    hs_q.push_back(PID_NAK);
    host_inst.token(PID_IN, 7'h05, EP_ONE);
    tx_q.push_back({PID_DATA0, 2'b10, 4'h2, 8'h3C});
    host_inst.token(PID_IN, 7'h05, EP_TWO);
    host_inst.ack();
    rd(ADDR_INT_FLAGS, 8'h00);
    repeat (4) @(negedge ref_clk_i);
    chk("pending results", 0, 18'(hs_q.size() + tx_q.size() + rd_q.size()));
    $display("test transmit done");
    summarize();
  end
endmodule : tb_ulse_core
`default_nettype wire
